// file: hdl/iex_core.sv
/*
 * Execution core for a subset of an 8-bit instruction set, with an
 * Avalon-MM register slave for run control and state readback.
 * Assumes synchronous program and data memories with one cycle of read
 * latency, and a return stack whose top entry is visible combinationally.
 */
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - Jump loads address, two cycles, no flags.
// RQ2 - Moves copy bytes without touching flags.
// RQ3 - Idle only advances the program counter.
// RQ4 - OR into accumulator, zero flag only.
// RQ5 - OR written back to memory, zero only.
// RQ6 - Return pops stack into program counter.
// RQ7 - Return with immediate also loads accumulator.
// RQ8 - Interrupt return pops and sets enable.
// RQ9 - Pending interrupt served before main program.
// RQ10 - Circular left rotate, no flags.
// RQ11 - Left rotate through carry, carry only.
// RQ12 - Circular right rotate, no flags.
// RQ13 - Right rotate through carry, carry only.
// RQ14 - Subtract with borrow into accumulator.
// RQ15 - Subtract with borrow into memory.
// RQ16 - Carry is inverted borrow after subtraction.
// RQ17 - Decrement memory, skip next if zero.
// RQ18 - Decrement into accumulator, skip if zero.
// RQ19 - Skip takes two instruction cycles.
// RQ20 - Set byte to all ones or one bit.
// RQ21 - Increment memory, skip next if zero.
// RQ22 - Increment into accumulator, skip if zero.
// RQ23 - Skipped instruction becomes harmless dummy cycle.
module iex_core (
   // Clock and reset.
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Register bus.
   input  wire logic [3:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output var  logic [31:0]        avs_readdata,
   output var  logic               avs_waitrequest,
   // Program memory.
   output var  logic [10:0]        pmem_addr,
   input  wire logic [15:0]        pmem_data,
   // Data memory.
   output var  iex_pkg::iex_dreq_t dmem_req,
   input  wire logic [7:0]         dmem_rdata,
   // Return stack.
   output var  iex_pkg::iex_sreq_t stack_req,
   input  wire logic [10:0]        stack_top,
   // Interrupts.
   input  wire logic               irq_req,
   output var  logic               irq_ack,
   output var  logic               master_irq_enable
);
   import iex_pkg::*;

   iex_state_t  state,     next_state;
   logic [10:0] pc,        next_pc;
   logic [15:0] ir,        next_ir;
   logic [7:0]  acc,       next_acc;
   iex_flags_t  flags,     next_flags;
   logic        next_mie;
   logic        dummy,     next_dummy;
   logic        dummy_adv, next_dummy_adv;
   iex_dreq_t   next_dreq;
   iex_sreq_t   next_sreq;
   logic        next_irq_ack;
   logic        ack,       next_ack;
   logic        run,       next_run;
   logic [31:0] next_rdata;
   logic        ctrl_wr;

   logic [4:0]  op;
   logic [7:0]  m;
   logic [7:0]  imm;
   logic [10:0] pc_inc;
   logic [7:0]  dec_v;
   logic [7:0]  inc_v;
   logic [8:0]  sub_full;
   logic [4:0]  sub_lo;
   logic        sub_ov;
   logic        irq_take;
   logic        exec_live;

   assign op        = ir[15:`IEX_OP_LSB];
   assign m         = dmem_rdata;
   assign imm       = ir[7:0];
   assign pc_inc    = pc + 11'h001;
   assign dec_v     = m - 8'h01;
   assign inc_v     = m + 8'h01;
   assign sub_full  = {1'b0, acc} + {1'b0, ~m} + {8'h00, flags.carry};
   assign sub_lo    = {1'b0, acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, flags.carry};
   assign sub_ov    = (acc[7] ^ m[7]) & (sub_full[7] ^ acc[7]);
   assign irq_take  = (state == IEX_FETCH) && master_irq_enable && irq_req && !dummy;
   assign exec_live = (state == IEX_EXEC) && !dummy;
   assign pmem_addr = pc;

   // Sequencer and datapath.
   always_comb begin
      next_state     = state;
      next_pc        = pc;
      next_ir        = ir;
      next_acc       = acc;
      next_flags     = flags;
      next_mie       = master_irq_enable;
      next_dummy     = dummy;
      next_dummy_adv = dummy_adv;
      next_dreq      = dmem_req;
      next_dreq.we   = 1'b0;
      next_sreq      = stack_req;
      next_sreq.push = 1'b0;
      next_sreq.pop  = 1'b0;
      next_irq_ack   = 1'b0;
      case (state)
         IEX_FETCH: begin
            // RQ9 entry at boundary.
            if (irq_take) begin
               next_sreq.push = 1'b1;
               next_sreq.data = pc;
               next_pc        = `IEX_IRQ_VEC;
               next_mie       = 1'b0;
               next_irq_ack   = 1'b1;
            end else if (run) begin
               next_state = IEX_DECODE;
            end
         end
         IEX_DECODE: begin
            next_ir        = pmem_data;
            next_dreq.addr = pmem_data[7:0];
            next_state     = IEX_READ;
         end
         IEX_READ: begin
            next_state = IEX_EXEC;
         end
         IEX_EXEC: begin
            next_state = IEX_FETCH;
            next_pc    = pc_inc;
            if (dummy) begin
               // RQ23 dummy changes nothing.
               next_dummy = 1'b0;
               if (!dummy_adv) begin
                  next_pc = pc;
               end
            end else begin
               case (op)
                  // RQ1 jump plus dummy.
                  `IEX_OP_JMP: begin
                     next_pc        = ir[10:0];
                     next_dummy     = 1'b1;
                     next_dummy_adv = 1'b0;
                  end
                  // RQ2 plain copies.
                  `IEX_OP_MOV_AM: next_acc = m;
                  `IEX_OP_MOV_AX: next_acc = imm;
                  `IEX_OP_MOV_MA: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = acc;
                  end
                  // RQ3 advance only.
                  `IEX_OP_IDLE: next_pc = pc_inc;
                  // RQ4 OR into accumulator.
                  `IEX_OP_OR_AM: begin
                     next_acc        = acc | m;
                     next_flags.zero = ((acc | m) == 8'h00);
                  end
                  `IEX_OP_OR_AX: begin
                     next_acc        = acc | imm;
                     next_flags.zero = ((acc | imm) == 8'h00);
                  end
                  // RQ5 OR into memory.
                  `IEX_OP_ORM: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = acc | m;
                     next_flags.zero = ((acc | m) == 8'h00);
                  end
                  // RQ6 RQ7 RQ8 returns pop stack.
                  `IEX_OP_RET, `IEX_OP_RET_AX, `IEX_OP_INTERRUPT_EXIT: begin
                     next_pc        = stack_top;
                     next_sreq.pop  = 1'b1;
                     next_dummy     = 1'b1;
                     next_dummy_adv = 1'b0;
                     if (op == `IEX_OP_RET_AX) begin
                        next_acc = imm;
                     end
                     if (op == `IEX_OP_INTERRUPT_EXIT) begin
                        next_mie = 1'b1;
                     end
                  end
                  // RQ10 circular left.
                  `IEX_OP_RL: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = {m[6:0], m[7]};
                  end
                  `IEX_OP_RLA: next_acc = {m[6:0], m[7]};
                  // RQ11 left through carry.
                  `IEX_OP_RLC: begin
                     next_dreq.we     = 1'b1;
                     next_dreq.wdata  = {m[6:0], flags.carry};
                     next_flags.carry = m[7];
                  end
                  `IEX_OP_ROTATE_LEFT_WITH_CARRY_TO_WORKING: begin
                     next_acc         = {m[6:0], flags.carry};
                     next_flags.carry = m[7];
                  end
                  // RQ12 circular right.
                  `IEX_OP_RR: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = {m[0], m[7:1]};
                  end
                  `IEX_OP_RRA: next_acc = {m[0], m[7:1]};
                  // RQ13 right through carry.
                  `IEX_OP_RRC: begin
                     next_dreq.we     = 1'b1;
                     next_dreq.wdata  = {flags.carry, m[7:1]};
                     next_flags.carry = m[0];
                  end
                  `IEX_OP_ROTATE_RIGHT_WITH_CARRY_TO_WORKING: begin
                     next_acc         = {flags.carry, m[7:1]};
                     next_flags.carry = m[0];
                  end
                  // RQ14 RQ15 RQ16 subtract with borrow.
                  `IEX_OP_SBC, `IEX_OP_SUBTRACT_WITH_BORROW_TO_MEMORY: begin
                     next_flags.carry           = sub_full[8];
                     next_flags.half_carry_flag = sub_lo[4];
                     next_flags.zero            = (sub_full[7:0] == 8'h00);
                     next_flags.sign_wrap_flag  = sub_ov;
                     if (op == `IEX_OP_SBC) begin
                        next_acc = sub_full[7:0];
                     end else begin
                        next_dreq.we    = 1'b1;
                        next_dreq.wdata = sub_full[7:0];
                     end
                  end
                  // RQ17 RQ18 RQ19 decrement and skip.
                  `IEX_OP_SDZ, `IEX_OP_DECREMENT_SKIP_IF_ZERO_TO_WORKING: begin
                     if (op == `IEX_OP_SDZ) begin
                        next_dreq.we    = 1'b1;
                        next_dreq.wdata = dec_v;
                     end else begin
                        next_acc = dec_v;
                     end
                     if (dec_v == 8'h00) begin
                        next_dummy     = 1'b1;
                        next_dummy_adv = 1'b1;
                     end
                  end
                  // RQ20 set byte or bit.
                  `IEX_OP_SET: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = `IEX_SET_BYTE;
                  end
                  `IEX_OP_SETB: begin
                     next_dreq.we    = 1'b1;
                     next_dreq.wdata = m | (8'h01 << ir[10:8]);
                  end
                  // RQ21 RQ22 RQ19 increment and skip.
                  `IEX_OP_SIZ, `IEX_OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING: begin
                     if (op == `IEX_OP_SIZ) begin
                        next_dreq.we    = 1'b1;
                        next_dreq.wdata = inc_v;
                     end else begin
                        next_acc = inc_v;
                     end
                     if (inc_v == 8'h00) begin
                        next_dummy     = 1'b1;
                        next_dummy_adv = 1'b1;
                     end
                  end
                  default: next_pc = pc_inc;
               endcase
            end
         end
         default: next_state = IEX_FETCH;
      endcase
      if (ctrl_wr && avs_writedata[`IEX_CTRL_MIE]) begin
         next_mie = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state             <= IEX_FETCH;
         pc                <= `IEX_PC_RST;
         ir                <= 16'h0000;
         acc               <= `IEX_ACC_RST;
         flags             <= '0;
         master_irq_enable <= 1'b0;
         dummy             <= 1'b0;
         dummy_adv         <= 1'b0;
         dmem_req          <= '0;
         stack_req         <= '0;
         irq_ack           <= 1'b0;
      end else begin
         state             <= next_state;
         pc                <= next_pc;
         ir                <= next_ir;
         acc               <= next_acc;
         flags             <= next_flags;
         master_irq_enable <= next_mie;
         dummy             <= next_dummy;
         dummy_adv         <= next_dummy_adv;
         dmem_req          <= next_dreq;
         stack_req         <= next_sreq;
         irq_ack           <= next_irq_ack;
      end
   end

   // Register slave with one wait state.
   assign avs_waitrequest = ~ack;
   assign ctrl_wr = avs_write && ack && (avs_address == `IEX_REG_CTRL) && avs_byteenable[0];

   always_comb begin
      next_ack   = (avs_read || avs_write) && !ack;
      next_run   = run;
      next_rdata = avs_readdata;
      if (avs_read && !ack) begin
         next_rdata = 32'h0000_0000;
         if (avs_address == `IEX_REG_CTRL) begin
            next_rdata[`IEX_CTRL_RUN] = run;
            next_rdata[`IEX_CTRL_MIE] = master_irq_enable;
         end else if (avs_address == `IEX_REG_STATE) begin
            next_rdata[`IEX_ST_ACC_LSB +: 8]  = acc;
            next_rdata[`IEX_ST_FLG_LSB +: 4]  = flags;
            next_rdata[`IEX_ST_MIE]           = master_irq_enable;
            next_rdata[`IEX_ST_PC_LSB +: 11]  = pc;
         end
      end
      if (ctrl_wr) begin
         next_run = avs_writedata[`IEX_CTRL_RUN];
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack          <= 1'b0;
         run          <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack          <= next_ack;
         run          <= next_run;
         avs_readdata <= next_rdata;
      end
   end

   // Checks.
   logic        sbc_no_borrow;
   assign sbc_no_borrow = ({1'b0, acc} >= ({1'b0, m} + {8'h00, ~flags.carry}));

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_jump_target: assert property ( // RQ1
      (exec_live && op == `IEX_OP_JMP) |=> (pc == $past(ir[10:0])) && dummy && $stable(flags)
   ) else $error("jump did not load target");
   a_copy_no_flag: assert property ( // RQ2
      (exec_live && op == `IEX_OP_MOV_AM) |=> (acc == $past(m)) && $stable(flags)
   ) else $error("copy wrong or flags moved");
   a_or_zero_only: assert property ( // RQ4
      (exec_live && op == `IEX_OP_OR_AM) |=> (acc == ($past(acc) | $past(m)))
         && (flags.zero == (acc == 8'h00)) && (flags.carry == $past(flags.carry))
   ) else $error("or into accumulator wrong");
   a_interrupt_exit_enable: assert property ( // RQ8
      (exec_live && op == `IEX_OP_INTERRUPT_EXIT) |=> master_irq_enable && stack_req.pop
         && (pc == $past(stack_top))
   ) else $error("interrupt return wrong");
   a_irq_first: assert property ( // RQ9
      irq_take |=> (pc == `IEX_IRQ_VEC) && stack_req.push && irq_ack && (state == IEX_FETCH)
   ) else $error("pending interrupt not entered");
   a_rotl_carry: assert property ( // RQ11
      (exec_live && op == `IEX_OP_RLC) |=> dmem_req.we
         && (dmem_req.wdata == {$past(m[6:0]), $past(flags.carry)}) && (flags.carry == $past(m[7]))
   ) else $error("left rotate through carry wrong");
   a_sbc_borrow: assert property ( // RQ16
      (exec_live && op == `IEX_OP_SBC) |=> (flags.carry == $past(sbc_no_borrow))
   ) else $error("subtract carry wrong");
   a_skip_timing: assert property ( // RQ19
      (exec_live && op == `IEX_OP_SDZ && dec_v == 8'h00)
         |=> dummy ##1 (state == IEX_DECODE) ##2 (state == IEX_EXEC && dummy)
   ) else $error("skip did not take a dummy cycle");
   a_dummy_inert: assert property ( // RQ23
      (state == IEX_EXEC && dummy) |=> $stable(acc) && $stable(flags) && !dmem_req.we
         && !stack_req.pop && !dummy
   ) else $error("dummy cycle changed state");
   a_set_byte: assert property ( // RQ20
      (exec_live && op == `IEX_OP_SET) |=> dmem_req.we && (dmem_req.wdata == `IEX_SET_BYTE)
   ) else $error("set byte wrong");

   c_jump:    cover property (exec_live && op == `IEX_OP_JMP);
   c_skip:    cover property (exec_live && op == `IEX_OP_SIZ && inc_v == 8'h00);
   c_interrupt_exit_irq: cover property ((exec_live && op == `IEX_OP_INTERRUPT_EXIT) ##[1:8] irq_take);
   c_sbc_neg: cover property (exec_live && op == `IEX_OP_SUBTRACT_WITH_BORROW_TO_MEMORY && !sub_full[8]);
endmodule : iex_core

`default_nettype wire

// file: hdl/iex_map.svh
/*
 * Offsets, field positions, reset values and opcode encodings of the
 * instruction execution subset.
 * Assumes it is included by its bare name from the package and the bench.
 */
`ifndef IEX_MAP_SVH
`define IEX_MAP_SVH
`define IEX_REG_CTRL    4'h0
`define IEX_REG_STATE   4'h4
`define IEX_CTRL_RUN    0
`define IEX_CTRL_MIE    1
`define IEX_ST_ACC_LSB  0
`define IEX_ST_FLG_LSB  8
`define IEX_ST_MIE      12
`define IEX_ST_PC_LSB   16
`define IEX_PC_RST      11'h000
`define IEX_ACC_RST     8'h00
`define IEX_IRQ_VEC     11'h004
`define IEX_SET_BYTE    8'hff
`define IEX_OP_LSB      11
`define IEX_OP_JMP      5'h00
`define IEX_OP_MOV_AM   5'h01
`define IEX_OP_MOV_AX   5'h02
`define IEX_OP_MOV_MA   5'h03
`define IEX_OP_IDLE     5'h04
`define IEX_OP_OR_AM    5'h05
`define IEX_OP_OR_AX    5'h06
`define IEX_OP_ORM      5'h07
`define IEX_OP_RET      5'h08
`define IEX_OP_RET_AX   5'h09
`define IEX_OP_INTERRUPT_EXIT     5'h0a
`define IEX_OP_RL       5'h0b
`define IEX_OP_RLA      5'h0c
`define IEX_OP_RLC      5'h0d
`define IEX_OP_ROTATE_LEFT_WITH_CARRY_TO_WORKING     5'h0e
`define IEX_OP_RR       5'h0f
`define IEX_OP_RRA      5'h10
`define IEX_OP_RRC      5'h11
`define IEX_OP_ROTATE_RIGHT_WITH_CARRY_TO_WORKING     5'h12
`define IEX_OP_SBC      5'h13
`define IEX_OP_SUBTRACT_WITH_BORROW_TO_MEMORY     5'h14
`define IEX_OP_SDZ      5'h15
`define IEX_OP_DECREMENT_SKIP_IF_ZERO_TO_WORKING     5'h16
`define IEX_OP_SET      5'h17
`define IEX_OP_SETB     5'h18
`define IEX_OP_SIZ      5'h19
`define IEX_OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING     5'h1a
`endif

// file: hdl/iex_pkg.sv
/*
 * Types shared by the execution core and its bench.
 * Assumes iex_map.svh is on the include path.
 */
package iex_pkg;
   `include "iex_map.svh"

   typedef enum logic [1:0] {IEX_FETCH, IEX_DECODE, IEX_READ, IEX_EXEC} iex_state_t;

   typedef struct packed {
      logic       carry;
      logic       half_carry_flag;
      logic       zero;
      logic       sign_wrap_flag;
   } iex_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
   } iex_dreq_t;

   typedef struct packed {
      logic        push;
      logic        pop;
      logic [10:0] data;
   } iex_sreq_t;
endpackage : iex_pkg

// file: verif/iex_mem_model.sv
/*
 * Program memory, data memory and return stack that sit beside the core.
 * Assumes the bench preloads the arrays and the stack depth before it starts the core.
 */
`timescale 1ns/1ps
`default_nettype none
module iex_mem_model (
   // Clock.
   input  wire logic               core_clk,
   // Program memory.
   input  wire logic [10:0]        pmem_addr,
   output var  logic [15:0]        pmem_data,
   // Data memory.
   input  wire iex_pkg::iex_dreq_t dmem_req,
   output var  logic [7:0]         dmem_rdata,
   // Return stack.
   input  wire iex_pkg::iex_sreq_t stack_req,
   output var  logic [10:0]        stack_top
);
   import iex_pkg::*;
   logic [15:0] prog [0:2047];
   logic [7:0]  dat  [0:255];
   logic [10:0] stk  [0:7];
   logic [2:0]  sp;
   logic [10:0] last_push;

   // Both memories answer one cycle after the address.
   always @(posedge core_clk) begin
      pmem_data  <= prog[pmem_addr];
      dmem_rdata <= dat[dmem_req.addr];
      if (dmem_req.we) begin
         dat[dmem_req.addr] <= dmem_req.wdata;
      end
      if (stack_req.pop) begin
         sp <= sp - 3'd1;
      end else if (stack_req.push) begin
         stk[sp]   <= stack_req.data;
         sp        <= sp + 3'd1;
         last_push <= stack_req.data;
      end
   end

   // An empty stack shows a pattern rather than a stale entry.
   assign stack_top = (sp != 3'd0) ? stk[sp - 3'd1] : ~last_push;
endmodule : iex_mem_model
`default_nettype wire

// file: verif/testbench.sv
/*
 * Self-checking bench: runs short programs and reads the core state back.
 * Assumes iex_map.svh is on the include path and the memory model beside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iex_map.svh"
module testbench;
   import iex_pkg::*;
   logic        core_clk;
   logic        rst;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [10:0] pmem_addr;
   logic [15:0] pmem_data;
   iex_dreq_t   dmem_req;
   logic [7:0]  dmem_rdata;
   iex_sreq_t   stack_req;
   logic [10:0] stack_top;
   logic        irq_req;
   logic        irq_ack;
   logic        master_irq_enable;
   logic        ack_seen;
   logic [31:0] rd;
   int          error_cnt;
   int          compares;
   int          cycles;
   int          pa;

   iex_core dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
      .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .stack_req(stack_req),
      .stack_top(stack_top), .irq_req(irq_req), .irq_ack(irq_ack),
      .master_irq_enable(master_irq_enable));

   iex_mem_model mem (.core_clk(core_clk), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
      .dmem_req(dmem_req), .dmem_rdata(dmem_rdata), .stack_req(stack_req),
      .stack_top(stack_top));

   always #2 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (irq_ack === 1'b1) begin
         ack_seen <= 1'b1;
         irq_req  <= 1'b0;
      end
      if (cycles == 6000) begin
         error_cnt++;
         conclude();
      end
   end

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask : bus_rd

   task automatic do_reset();
      rst <= 1'b1;
      for (int i = 0; i < 2048; i++) mem.prog[i] = {`IEX_OP_IDLE, 11'h000};
      for (int i = 0; i < 256; i++) mem.dat[i] = 8'h00;
      mem.sp = 3'd0;
      pa = 0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic p(input logic [4:0] op, input logic [2:0] b, input logic [7:0] m);
      mem.prog[pa] = {op, b, m};
      pa++;
   endtask : p

   // Starts the core and polls the state until the closing loop is reached.
   task automatic run_prog(input logic [10:0] stop_pc);
      int n;
      n = 0;
      bus_wr(`IEX_REG_CTRL, 32'h1);
      do begin
         bus_rd(`IEX_REG_STATE, rd);
         n++;
      end while (rd[26:16] !== stop_pc && n < 300);
      check(rd[26:16], stop_pc); // Stop address reached.
   endtask : run_prog

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      irq_req = 1'b0;
      ack_seen = 1'b0;
      error_cnt = 0;
      compares = 0;
      cycles = 0;
      do_reset();
      bus_rd(`IEX_REG_STATE, rd);
      check(rd, 32'h0);              // Nothing moves while parked.
      bus_rd(4'h8, rd);
      check(rd, 32'h0);              // Unmapped reads as zero.
      bus_wr(4'hc, 32'hffff_ffff);
      $display("test registers done");

      do_reset();
      mem.dat[8'h10] = 8'h81; mem.dat[8'h11] = 8'h01; mem.dat[8'h12] = 8'hff;
      mem.dat[8'h14] = 8'h02;
      p(`IEX_OP_MOV_AX, 3'd0, 8'h0f); p(`IEX_OP_OR_AM, 3'd0, 8'h10);
      p(`IEX_OP_MOV_MA, 3'd0, 8'h20); p(`IEX_OP_RL, 3'd0, 8'h10);
      p(`IEX_OP_RLA, 3'd0, 8'h10);    p(`IEX_OP_RRC, 3'd0, 8'h11);
      p(`IEX_OP_ROTATE_LEFT_WITH_CARRY_TO_WORKING, 3'd0, 8'h14);   p(`IEX_OP_SIZ, 3'd0, 8'h12);
      p(`IEX_OP_MOV_AX, 3'd0, 8'hee); p(`IEX_OP_DECREMENT_SKIP_IF_ZERO_TO_WORKING, 3'd0, 8'h14);
      p(`IEX_OP_SET, 3'd0, 8'h21);    p(`IEX_OP_SETB, 3'd3, 8'h13);
      p(`IEX_OP_SBC, 3'd0, 8'h13);    p(`IEX_OP_JMP, 3'd0, 8'h0d);
      run_prog(11'h00d);
      check(rd[7:0], 8'hf8);         // Borrow subtract result.
      check(rd[11:8], 4'h0);         // Negative clears carry.
      check(mem.dat[8'h20], 8'h8f);  // Merged byte copied out.
      check(mem.dat[8'h10], 8'h03);  // Circular left rotate.
      check(mem.dat[8'h11], 8'h00);  // Rotate through carry.
      check(mem.dat[8'h12], 8'h00);  // Incremented byte.
      check(mem.dat[8'h14], 8'h02);  // Memory kept.
      check(mem.dat[8'h21], 8'hff);  // Whole byte set.
      check(mem.dat[8'h13], 8'h08);  // Single bit set.
      $display("test ops_a done");

      do_reset();
      mem.dat[8'h31] = 8'h01; mem.dat[8'h32] = 8'hff; mem.dat[8'h33] = 8'h80;
      mem.dat[8'h34] = 8'h01;
      mem.stk[0] = 11'h011; mem.stk[1] = 11'h00f; mem.stk[2] = 11'h00e; mem.sp = 3'd3;
      p(`IEX_OP_MOV_AX, 3'd0, 8'h00); p(`IEX_OP_ORM, 3'd0, 8'h30);
      p(`IEX_OP_SDZ, 3'd0, 8'h31);    p(`IEX_OP_MOV_AX, 3'd0, 8'h55);
      p(`IEX_OP_INCREMENT_SKIP_IF_ZERO_TO_WORKING, 3'd0, 8'h32);   p(`IEX_OP_MOV_AX, 3'd0, 8'h66);
      p(`IEX_OP_RR, 3'd0, 8'h33);     p(`IEX_OP_RRA, 3'd0, 8'h34);
      p(`IEX_OP_ROTATE_RIGHT_WITH_CARRY_TO_WORKING, 3'd0, 8'h34);   p(`IEX_OP_RLC, 3'd0, 8'h33);
      p(`IEX_OP_OR_AX, 3'd0, 8'h80);  p(`IEX_OP_SUBTRACT_WITH_BORROW_TO_MEMORY, 3'd0, 8'h34);
      p(`IEX_OP_RET, 3'd0, 8'h00);    p(`IEX_OP_MOV_AX, 3'd0, 8'h99);
      p(`IEX_OP_INTERRUPT_EXIT, 3'd0, 8'h00);   p(`IEX_OP_RET_AX, 3'd0, 8'h3c);
      p(`IEX_OP_MOV_AX, 3'd0, 8'h77); p(`IEX_OP_IDLE, 3'd0, 8'h00);
      p(`IEX_OP_JMP, 3'd0, 8'h12);
      run_prog(11'h012);
      check(rd[7:0], 8'h3c);         // Return loads immediate.
      check(rd[11:8], 4'h9);         // Carry and overflow set.
      check(rd[12], 1'b1);           // Enable set on return.
      check(mem.sp, 3'd0);           // Three entries popped.
      check(mem.dat[8'h31], 8'h00);  // Decremented byte.
      check(mem.dat[8'h32], 8'hff);  // Memory kept.
      check(mem.dat[8'h33], 8'h81);  // Rotate through carry.
      check(mem.dat[8'h34], 8'h7e);  // Result in memory.
      check(mem.dat[8'h30], 8'h00);  // Merge written back.
      $display("test ops_b done");

      do_reset();
      mem.stk[0] = 11'h005;
      mem.sp = 3'd1;
      p(`IEX_OP_INTERRUPT_EXIT, 3'd0, 8'h00);
      mem.prog[4] = {`IEX_OP_JMP, 11'h004};
      mem.prog[5] = {`IEX_OP_MOV_AX, 3'd0, 8'h11};
      ack_seen = 1'b0;
      irq_req <= 1'b1;
      run_prog(11'h004);
      check(ack_seen, 1'b1);         // Pending request served.
      check(rd[7:0], 8'h00);         // Main program held off.
      check(mem.last_push, 11'h005); // Return address saved.
      bus_wr(`IEX_REG_CTRL, 32'h2);
      bus_rd(`IEX_REG_STATE, rd);
      check(rd[12], 1'b1);           // Enable set by software.
      $display("test irq_return done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
